// ---- inc/afc_pkg.sv ----
// Purpose: Shared constants for the amplifier/filter parameter command engine
// Assumes: 32-bit Avalon-MM register bus, 40 MHz clock
// Notes:   Float range limits are parameters of the top module
package afc_pkg;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_SETUP                   = 8'h00;
  localparam logic [7:0] CMD_GET_LOWPASS_CORNER      = 8'h01;
  localparam logic [7:0] CMD_GET_HIGHPASS_CORNER     = 8'h02;
  localparam logic [7:0] CMD_GET_AMPLIFICATION       = 8'h03;
  localparam logic [7:0] CMD_GET_INPUT_COUPLING      = 8'h04;
  localparam logic [7:0] CMD_GET_FILTER_CLOCK_SELECT = 8'h05;
  localparam logic [7:0] CMD_GET_PACER_OUTPUT        = 8'h06;
  localparam logic [7:0] CMD_GET_CHANNEL_LABEL_NUM   = 8'h07;
  localparam logic [7:0] CMD_GET_LABEL_CHAR          = 8'h08;
  localparam logic [7:0] CMD_GET_LOWPASS_KIND        = 8'h09;
  localparam logic [7:0] CMD_GET_HIGHPASS_KIND       = 8'h0A;
  localparam logic [7:0] CMD_GET_UNIT_SERIAL         = 8'h0B;
  localparam logic [7:0] CMD_GET_VARIANT_CODE        = 8'h0C;
  localparam logic [7:0] CMD_GET_FIRMWARE_VERSION    = 8'h0D;
  localparam logic [7:0] CMD_SET_LOWPASS_CORNER      = 8'h0E;
  localparam logic [7:0] CMD_SET_HIGHPASS_CORNER     = 8'h0F;
  localparam logic [7:0] CMD_SET_AMPLIFICATION       = 8'h10;
  localparam logic [7:0] CMD_SET_INPUT_COUPLING      = 8'h11;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [3:0] ADDR_CMD    = 4'h0; // Write: command code, starts command
  localparam logic [3:0] ADDR_IN     = 4'h4; // Host to unit word
  localparam logic [3:0] ADDR_OUT    = 4'h8; // Unit to host word
  localparam logic [3:0] ADDR_STATUS = 4'hC; // Setup done in bit 1; bit 0 always reads zero

  // ****************************************
  // Status codes, fields, limits
  // ****************************************
  localparam logic [31:0] ST_OK       = 32'h0000_0000;
  localparam logic [31:0] ST_LP_RANGE = 32'h0000_0001;
  localparam logic [31:0] ST_HP_RANGE = 32'h0000_0002;
  localparam logic [31:0] ST_GN_RANGE = 32'h0000_0003;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
  localparam logic [3:0]  GAIN_MAX_OLD = 4'hA;    // Up to 2000x
  localparam logic [3:0]  GAIN_MAX_NEW = 4'hC;    // Up to 10000x
  localparam logic [3:0]  GAIN_RESET   = 4'h0;
  localparam int          LABEL_LEN    = 16;
  localparam int          LABEL_AW     = 4;
  localparam logic [15:0] LABEL_END    = 16'h0000; // Terminator character

  typedef enum logic [1:0] {
    AFC_IDLE = 2'b00,
    AFC_EXEC = 2'b01,
    AFC_DONE = 2'b11
  } afc_state_t;

endpackage : afc_pkg

// ---- design/afc_float_check.sv ----
// Purpose: Range check of an IEEE single against two bounds
// Assumes: Bounds are positive, finite
// Notes:   Compares bit patterns, valid for non-negative floats
`timescale 1ns/1ps
module afc_float_check
  import afc_pkg::*;
(
  input  wire logic [31:0] value,  // Candidate float
  input  wire logic [31:0] lo,     // Lowest legal float
  input  wire logic [31:0] hi,     // Highest legal float
  output      logic        ok      // Value lies within bounds
);
  // Positive floats order like unsigned integers; a sign bit or NaN fails
  always_comb begin
    ok = !value[31] && (value >= lo) && (value <= hi) && (value[30:23] != 8'hFF);
  end
endmodule : afc_float_check

// ---- design/afc_label_rom.sv ----
// Purpose: Label character store indexed by position
// Assumes: Contents fixed at build time
// Notes:   Past the end the terminator is returned
`timescale 1ns/1ps
module afc_label_rom
  import afc_pkg::*;
#(
  parameter logic [LABEL_LEN*16-1:0] TEXT = '0  // Characters, index 0 in low bits
) (
  input  wire logic [15:0] index,  // Character position
  output      logic [15:0] char_out // Character at position
);
  // Out-of-range positions read the terminator so the host always stops
  always_comb begin
    if (index < 16'(LABEL_LEN)) begin
      char_out = TEXT[index[LABEL_AW-1:0]*16 +: 16];
    end else begin
      char_out = LABEL_END;
    end
  end
endmodule : afc_label_rom

// ---- design/afc_cmd_engine.sv ----
// Purpose: Parameter command interpreter, reads and writes module settings
// Assumes: Host drives Avalon-MM; one command in flight at a time
// Notes:   Writing the command register starts the command; result in OUT
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - Every value is one 32-bit word
// - Code 1 returns lowpass corner float
// - Code 2 returns highpass corner float
// - Code 3 returns gain index
// - Gain index 0..10, 11-12 newer only
// - Code 4 returns coupling, 0 DC
// - Code 5 returns filter clock source
// - Code 6 returns pacer output enable
// - Code 7 returns channel number, informational
// - Code 8 returns position and character
// - Code 9 returns lowpass kind index
// - Code 10 returns highpass kind index
// - Code 11 returns serial number
// - Code 12 returns variant code
// - Code 13 returns packed major.minor version
// - Code 14 sets lowpass, status 1 bad
// - Code 15 sets highpass, status 2 bad
// - Code 16 sets gain, status 3 bad
// - Code 17 takes coupling from bit 0
module afc_cmd_engine
  import afc_pkg::*;
#(
  parameter logic [31:0] LP_RESET     = 32'h4700_0000, // Lowpass corner at reset
  parameter logic [31:0] HP_RESET     = 32'h3F80_0000, // Highpass corner at reset
  parameter logic [31:0] LP_MIN       = 32'h3F80_0000, // Lowest lowpass corner
  parameter logic [31:0] LP_MAX       = 32'h4843_5000, // Highest lowpass corner
  parameter logic [31:0] HP_MIN       = 32'h3DCC_CCCD, // Lowest highpass corner
  parameter logic [31:0] HP_MAX       = 32'h4620_0000, // Highest highpass corner
  parameter logic        NEW_FIRMWARE = 1'b1,          // Enables gain 11 and 12
  parameter logic [31:0] LP_KIND      = 32'h0000_0004, // Installed lowpass kind
  parameter logic [31:0] HP_KIND      = 32'h0000_0000, // Installed highpass kind
  parameter logic [31:0] SERIAL       = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] VARIANT      = 32'h0000_0000, // Arbitrary value
  parameter logic [15:0] REV_MAJOR    = 16'h0001,      // Arbitrary value
  parameter logic [15:0] REV_MINOR    = 16'h0000,      // Arbitrary value
  parameter logic [31:0] CHANNEL_NUM  = 32'h0000_0000, // Channel label number
  parameter logic [LABEL_LEN*16-1:0] LABEL = '0        // Label text
) (
  input  wire logic        clk,             // 40 MHz clock
  input  wire logic        reset,           // Synchronous, active high
  input  wire logic [3:0]  address,         // Avalon byte address
  input  wire logic        read,            // Avalon read
  input  wire logic        write,           // Avalon write
  input  wire logic [31:0] writedata,       // Avalon write data
  input  wire logic [3:0]  byteenable,      // Avalon byte enables
  output      logic [31:0] readdata,        // Avalon read data
  output      logic        waitrequest,     // Avalon wait
  output      logic [31:0] lowpass_corner_freq,  // Applied lowpass corner
  output      logic [31:0] highpass_corner_freq, // Applied highpass corner
  output      logic [3:0]  gain_index,      // Applied gain index
  output      logic        ac_coupled,      // 1 = AC coupling
  output      logic        ext_filter_clk,  // 1 = external filter clock
  output      logic        pacer_out_en     // 1 = pacer pin driven
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    afc_state_t  state;
    logic [7:0]  command_code;
    logic [31:0] host_to_unit_word;
    logic [31:0] unit_to_host_word;
    logic [31:0] lp;
    logic [31:0] hp;
    logic [3:0]  gain;
    logic        coupling;
    logic        clk_sel;
    logic        pacer;
    logic        setup_done;
    logic        ack;
    logic [31:0] rdata;
  } afc_regs_t;

  afc_regs_t r;
  afc_regs_t next_r;
  logic        lp_ok;
  logic        hp_ok;
  logic [15:0] label_char;

  // Gain limit depends on firmware generation
  function automatic logic gain_legal(input logic [31:0] v);
    gain_legal = (v <= 32'(NEW_FIRMWARE ? GAIN_MAX_NEW : GAIN_MAX_OLD));
  endfunction : gain_legal

  // Byte-lane merge for writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      lane_merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : lane_merge

  afc_float_check u_lp_chk (
    .value (r.host_to_unit_word),
    .lo    (LP_MIN),
    .hi    (LP_MAX),
    .ok    (lp_ok)
  );

  afc_float_check u_hp_chk (
    .value (r.host_to_unit_word),
    .lo    (HP_MIN),
    .hi    (HP_MAX),
    .ok    (hp_ok)
  );

  afc_label_rom #(.TEXT(LABEL)) u_label (
    .index    (r.host_to_unit_word[31:16]),
    .char_out (label_char)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  // Accesses in idle complete in one wait cycle; any access to any
  // register while busy is held off by waitrequest until idle
  always_comb begin
    next_r       = r;
    next_r.ack   = 1'b0;
    next_r.rdata = WORD_ZERO;
    case (r.state)
      AFC_IDLE: begin
        if ((read || write) && !r.ack) begin
          next_r.ack = 1'b1;
          if (address == ADDR_CMD) begin
            if (write) begin
              next_r.command_code = writedata[7:0];
              next_r.state        = AFC_EXEC;
            end else begin
              next_r.rdata = {24'h00_0000, r.command_code};
            end
          end else if (address == ADDR_IN) begin
            if (write) begin
              next_r.host_to_unit_word = lane_merge(r.host_to_unit_word, writedata,
                                                    byteenable);
            end else begin
              next_r.rdata = r.host_to_unit_word;
            end
          end else if (address == ADDR_OUT) begin
            next_r.rdata = r.unit_to_host_word;
          end else if (address == ADDR_STATUS) begin
            next_r.rdata = {30'h0000_0000, r.setup_done, 1'b0};
          end else begin
            next_r.rdata = WORD_ZERO;          // Unmapped reads zero
          end
        end
      end
      AFC_EXEC: begin
        next_r.state = AFC_DONE;
        case (r.command_code)
          CMD_SETUP: begin
            next_r.setup_done        = 1'b1;
            next_r.unit_to_host_word = ST_OK;
          end
          CMD_GET_LOWPASS_CORNER:      next_r.unit_to_host_word = r.lp;
          CMD_GET_HIGHPASS_CORNER:     next_r.unit_to_host_word = r.hp;
          CMD_GET_AMPLIFICATION:       next_r.unit_to_host_word = 32'(r.gain);
          CMD_GET_INPUT_COUPLING:      next_r.unit_to_host_word = 32'(r.coupling);
          CMD_GET_FILTER_CLOCK_SELECT: next_r.unit_to_host_word = 32'(r.clk_sel);
          CMD_GET_PACER_OUTPUT:        next_r.unit_to_host_word = 32'(r.pacer);
          CMD_GET_CHANNEL_LABEL_NUM:   next_r.unit_to_host_word = CHANNEL_NUM;
          CMD_GET_LABEL_CHAR: begin
            next_r.unit_to_host_word = {r.host_to_unit_word[31:16], label_char};
          end
          CMD_GET_LOWPASS_KIND:        next_r.unit_to_host_word = LP_KIND;
          CMD_GET_HIGHPASS_KIND:       next_r.unit_to_host_word = HP_KIND;
          CMD_GET_UNIT_SERIAL:         next_r.unit_to_host_word = SERIAL;
          CMD_GET_VARIANT_CODE:        next_r.unit_to_host_word = VARIANT;
          CMD_GET_FIRMWARE_VERSION: begin
            next_r.unit_to_host_word = {REV_MAJOR, REV_MINOR};
          end
          CMD_SET_LOWPASS_CORNER: begin
            if (lp_ok) begin
              next_r.lp                = r.host_to_unit_word;
              next_r.unit_to_host_word = ST_OK;
            end else begin
              next_r.unit_to_host_word = ST_LP_RANGE;
            end
          end
          CMD_SET_HIGHPASS_CORNER: begin
            if (hp_ok) begin
              next_r.hp                = r.host_to_unit_word;
              next_r.unit_to_host_word = ST_OK;
            end else begin
              next_r.unit_to_host_word = ST_HP_RANGE;
            end
          end
          CMD_SET_AMPLIFICATION: begin
            if (gain_legal(r.host_to_unit_word)) begin
              next_r.gain              = r.host_to_unit_word[3:0];
              next_r.unit_to_host_word = ST_OK;
            end else begin
              next_r.unit_to_host_word = ST_GN_RANGE;
            end
          end
          CMD_SET_INPUT_COUPLING: begin
            next_r.coupling          = r.host_to_unit_word[0];
            next_r.unit_to_host_word = ST_OK;
          end
          default: next_r.unit_to_host_word = WORD_ZERO; // Unknown codes answer zero
        endcase
      end
      AFC_DONE: begin
        next_r.state = AFC_IDLE;
      end
      default: next_r.state = AFC_IDLE;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      r            <= '0;
      r.state      <= AFC_IDLE;
      r.lp         <= LP_RESET;
      r.hp         <= HP_RESET;
      r.gain       <= GAIN_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops except waitrequest, which gates read and write with ack; ack stays set only one cycle
  always_comb begin
    readdata             = r.rdata;
    waitrequest          = (read || write) && !r.ack;
    lowpass_corner_freq  = r.lp;
    highpass_corner_freq = r.hp;
    gain_index           = r.gain;
    ac_coupled           = r.coupling;
    ext_filter_clk       = r.clk_sel;
    pacer_out_en         = r.pacer;
  end

  // ****************************************
  // Checks
  // ****************************************
  // Condition folded in so no sequence meets a logical operator
  sequence s_exec(logic [7:0] c, logic cond);
    r.state == AFC_EXEC && r.command_code == c && cond;
  endsequence

  // Executing command always retires through done to idle
  sequence s_finish;
    r.state == AFC_DONE ##1 r.state == AFC_IDLE;
  endsequence

  chk_gain_reject: assert property (@(posedge clk) disable iff (reset)
    s_exec(CMD_SET_AMPLIFICATION, !gain_legal(r.host_to_unit_word)) |=>
      r.unit_to_host_word == ST_GN_RANGE && $stable(r.gain))
    else $error("gain reject wrong");
  chk_gain_range: assert property (@(posedge clk) disable iff (reset)
    r.gain <= GAIN_MAX_NEW) else $error("gain index out of table");
  chk_lp_reject: assert property (@(posedge clk) disable iff (reset)
    s_exec(CMD_SET_LOWPASS_CORNER, !lp_ok) |=>
      r.unit_to_host_word == ST_LP_RANGE && $stable(r.lp))
    else $error("lowpass reject wrong");
  chk_lp_apply: assert property (@(posedge clk) disable iff (reset)
    s_exec(CMD_SET_LOWPASS_CORNER, lp_ok) |=>
      r.lp == $past(r.host_to_unit_word) && r.unit_to_host_word == ST_OK)
    else $error("lowpass not applied");
  chk_hp_reject: assert property (@(posedge clk) disable iff (reset)
    s_exec(CMD_SET_HIGHPASS_CORNER, !hp_ok) |=>
      r.unit_to_host_word == ST_HP_RANGE && $stable(r.hp))
    else $error("highpass reject wrong");
  chk_coupling_lsb: assert property (@(posedge clk) disable iff (reset)
    s_exec(CMD_SET_INPUT_COUPLING, 1'b1) |=> r.coupling == $past(r.host_to_unit_word[0]))
    else $error("coupling not from bit 0");
  chk_label_pos: assert property (@(posedge clk) disable iff (reset)
    s_exec(CMD_GET_LABEL_CHAR, 1'b1) |=>
      r.unit_to_host_word[31:16] == $past(r.host_to_unit_word[31:16]))
    else $error("label position wrong");
  chk_gain_read: assert property (@(posedge clk) disable iff (reset)
    s_exec(CMD_GET_AMPLIFICATION, 1'b1) |=> r.unit_to_host_word == 32'($past(r.gain)))
    else $error("gain read wrong");
  chk_cmd_done: assert property (@(posedge clk) disable iff (reset)
    r.state == AFC_EXEC |=> s_finish)
    else $error("command did not finish");

endmodule : afc_cmd_engine

// ---- bench/afc_host_model.sv ----
// Purpose: Host side model that issues parameter commands over Avalon-MM
// Assumes: One command in flight; answers come once waitrequest falls
// Notes:   Released write data is inverted so a stale word cannot pass
`timescale 1ns/1ps
module afc_host_model
  import afc_pkg::*;
(
  input  wire logic        clk,         // Bus clock
  output      logic [3:0]  address,     // Byte address
  output      logic        read,        // Read strobe
  output      logic        write,       // Write strobe
  output      logic [31:0] writedata,   // Write data
  output      logic [3:0]  byteenable,  // Lane enables
  input  wire logic [31:0] readdata,    // Read data
  input  wire logic        waitrequest  // Slave stall
);
  logic [31:0] label_words [$];  // Label words as returned
  logic [31:0] dummy;            // Unused answer
  logic [3:0]  lanes = 4'hF;     // Byte enables for the next access

  // ****************************************
  // Bus cycles
  // ****************************************
  // Idle bus from time zero
  initial begin
    address    = 4'h0;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h0000_0000;
    byteenable = 4'hF;
  end

  // Request held until waitrequest is sampled low at a rising edge; data taken there
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    address    <= a;
    read       <= ~wr;
    write      <= wr;
    writedata  <= d;
    byteenable <= lanes;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = readdata;
    read      <= 1'b0;
    write     <= 1'b0;
    writedata <= ~d;
  endtask : xfer

  // Input word, then code, then the answer word
  task automatic run_cmd(input logic [7:0] code, input logic [31:0] in_w,
                         output logic [31:0] out_w);
    xfer(1'b1, ADDR_IN, in_w, dummy);
    xfer(1'b1, ADDR_CMD, {24'h00_0000, code}, dummy);
    xfer(1'b0, ADDR_OUT, 32'h0000_0000, out_w);
  endtask : run_cmd

  // Setup goes first of all commands
  task automatic setup();
    run_cmd(CMD_SETUP, 32'h0000_0000, dummy);
  endtask : setup

  // One character per call until the terminator; at most one call more than the label length
  task automatic read_label();
    logic [31:0] w;
    label_words.delete();
    for (int p = 0; p <= LABEL_LEN; p++) begin
      run_cmd(CMD_GET_LABEL_CHAR, {16'(p), 16'h0000}, w);
      label_words.push_back(w);
      if (w[15:0] === LABEL_END) break;
    end
  endtask : read_label
endmodule : afc_host_model

// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench for the parameter command engine
// Assumes: Host model drives the register bus; identity values are arbitrary
// Notes:   Set commands are checked by status word; some are followed by a readback or a port check
`timescale 1ns/1ps
module tb_top
  import afc_pkg::*;
;
  localparam logic [31:0] T_LP_RST = 32'h4700_0000;
  localparam logic [31:0] T_LP_MAX = 32'h4843_5000;
  localparam logic [31:0] T_HP_MIN = 32'h3DCC_CCCD;
  localparam logic [31:0] T_SERIAL = 32'h0000_1234;  // Arbitrary value
  localparam logic [31:0] T_VARIANT = 32'h0000_0009; // Arbitrary value
  localparam logic [31:0] T_CHAN   = 32'h0000_0007;
  localparam logic [255:0] T_LABEL = {224'h0, 16'h004B, 16'h004F};
  logic        clk, reset, read, write, waitrequest, ac_coupled, ext_filter_clk, pacer_out_en;
  logic [3:0]  address, byteenable, gain_index;
  logic [31:0] writedata, readdata, lowpass_corner_freq, highpass_corner_freq, q;
  int          miscompares = 0;
  int          checked = 0;

  afc_host_model host (.clk(clk), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));

  afc_cmd_engine #(.LP_RESET(T_LP_RST), .LP_MAX(T_LP_MAX), .HP_MIN(T_HP_MIN),
    .NEW_FIRMWARE(1'b1), .LP_KIND(32'h0000_000D), .HP_KIND(32'h0000_0004),
    .SERIAL(T_SERIAL), .VARIANT(T_VARIANT), .REV_MAJOR(16'h0005),
    .REV_MINOR(16'h0002), .CHANNEL_NUM(T_CHAN), .LABEL(T_LABEL)) dut (
    .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .lowpass_corner_freq(lowpass_corner_freq),
    .highpass_corner_freq(highpass_corner_freq), .gain_index(gain_index),
    .ac_coupled(ac_coupled), .ext_filter_clk(ext_filter_clk), .pacer_out_en(pacer_out_en));

  // ****************************************
  // Helpers
  // ****************************************
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // Read command with a noisy input word, which must make no difference
  task automatic rd(input logic [7:0] c, input logic [31:0] e, input string m);
    host.run_cmd(c, 32'hA5A5_5A5A, q);
    check(q, e, m);
  endtask : rd

  task automatic wr(input logic [7:0] c, input logic [31:0] v, input logic [31:0] e,
                    input string m);
    host.run_cmd(c, v, q);
    check(q, e, m);
  endtask : wr

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset_and_ids();
    check(lowpass_corner_freq, T_LP_RST, "lowpass at reset");
    check({24'h0, gain_index, 1'b0, ac_coupled, ext_filter_clk, pacer_out_en}, 32'h0, "reset");
    host.xfer(1'b0, ADDR_STATUS, 32'h0000_0000, q);
    check(q, 32'h0000_0000, "status before setup");
    host.setup();
    host.xfer(1'b0, ADDR_STATUS, 32'h0000_0000, q);
    check(q, 32'h0000_0002, "status after setup");
    host.xfer(1'b0, 4'h2, 32'h0000_0000, q);
    check(q, 32'h0000_0000, "unmapped read");
    rd(CMD_GET_LOWPASS_CORNER, T_LP_RST, "lowpass read");
    rd(CMD_GET_HIGHPASS_CORNER, 32'h3F80_0000, "highpass read");
    rd(CMD_GET_FILTER_CLOCK_SELECT, 32'h0000_0000, "clock select");
    rd(CMD_GET_PACER_OUTPUT, 32'h0000_0000, "pacer output");
    rd(CMD_GET_CHANNEL_LABEL_NUM, T_CHAN, "channel number");
    rd(CMD_GET_LOWPASS_KIND, 32'h0000_000D, "lowpass kind");
    rd(CMD_GET_HIGHPASS_KIND, 32'h0000_0004, "highpass kind");
    rd(CMD_GET_UNIT_SERIAL, T_SERIAL, "serial");
    rd(CMD_GET_VARIANT_CODE, T_VARIANT, "variant");
    rd(CMD_GET_FIRMWARE_VERSION, 32'h0005_0002, "version");
  endtask : test_reset_and_ids

  task automatic test_label();
    host.read_label();
    check(32'(host.label_words.size()), 32'd3, "label length");
    check(host.label_words[0], 32'h0000_004F, "first char");
    check(host.label_words[1], 32'h0001_004B, "second char");
    check(host.label_words[2], {16'h0002, LABEL_END}, "terminator");
  endtask : test_label

  task automatic test_corners();
    wr(CMD_SET_LOWPASS_CORNER, 32'h4500_0000, ST_OK, "lowpass set");
    wr(CMD_SET_LOWPASS_CORNER, 32'h4900_0000, ST_LP_RANGE, "lowpass high");
    check(lowpass_corner_freq, 32'h4500_0000, "lowpass kept");
    wr(CMD_SET_LOWPASS_CORNER, T_LP_MAX, ST_OK, "lowpass top");
    wr(CMD_SET_LOWPASS_CORNER, 32'h3F7F_FFFF, ST_LP_RANGE, "lowpass low");
    rd(CMD_GET_LOWPASS_CORNER, T_LP_MAX, "lowpass readback");
    wr(CMD_SET_HIGHPASS_CORNER, 32'h4120_0000, ST_OK, "highpass set");
    wr(CMD_SET_HIGHPASS_CORNER, 32'h4620_0001, ST_HP_RANGE, "highpass high");
    check(highpass_corner_freq, 32'h4120_0000, "highpass kept");
    wr(CMD_SET_HIGHPASS_CORNER, T_HP_MIN, ST_OK, "highpass bottom");
    rd(CMD_GET_HIGHPASS_CORNER, T_HP_MIN, "highpass readback");
  endtask : test_corners

  task automatic test_gain_coupling();
    for (int g = 0; g <= 12; g++) begin
      wr(CMD_SET_AMPLIFICATION, 32'(g), ST_OK, "gain set");
      rd(CMD_GET_AMPLIFICATION, 32'(g), "gain read");
    end
    wr(CMD_SET_AMPLIFICATION, 32'h0000_000D, ST_GN_RANGE, "gain 13");
    wr(CMD_SET_AMPLIFICATION, 32'h8000_000C, ST_GN_RANGE, "gain wide");
    check({28'h0, gain_index}, 32'h0000_000C, "gain kept");
    rd(CMD_GET_AMPLIFICATION, 32'h0000_000C, "gain read kept");
    wr(CMD_SET_INPUT_COUPLING, 32'hFFFF_FFFF, ST_OK, "coupling ac");
    rd(CMD_GET_INPUT_COUPLING, 32'h0000_0001, "coupling read ac");
    wr(CMD_SET_INPUT_COUPLING, 32'hFFFF_FFFE, ST_OK, "coupling dc");
    check({31'h0, ac_coupled}, 32'h0000_0000, "coupling port");
    rd(CMD_GET_INPUT_COUPLING, 32'h0000_0000, "coupling read dc");
    check({30'h0, ext_filter_clk, pacer_out_en}, 32'h0, "other switches");
  endtask : test_gain_coupling

  // Partial lanes merge into IN; OUT ignores writes; CMD reads back
  task automatic test_lanes();
    host.xfer(1'b1, ADDR_IN, 32'h1111_1111, q);
    host.lanes = 4'h3;
    host.xfer(1'b1, ADDR_IN, 32'hAAAA_BBBB, q);
    host.lanes = 4'hF;
    host.xfer(1'b0, ADDR_IN, 32'h0000_0000, q);
    check(q, 32'h1111_BBBB, "lane merge");
    host.xfer(1'b1, ADDR_OUT, 32'hDEAD_BEEF, q);
    host.xfer(1'b0, ADDR_OUT, 32'h0000_0000, q);
    check(q, 32'h0000_0000, "out not writable");
    host.xfer(1'b0, ADDR_CMD, 32'h0000_0000, q);
    check(q, {24'h00_0000, CMD_GET_INPUT_COUPLING}, "command readback");
  endtask : test_lanes

  // Reset in mid-run restores every setting and clears setup
  task automatic test_mid_reset();
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check(lowpass_corner_freq, T_LP_RST, "lowpass after reset");
    check(highpass_corner_freq, 32'h3F80_0000, "highpass after reset");
    check({24'h0, gain_index, 1'b0, ac_coupled, ext_filter_clk, pacer_out_en}, 32'h0,
          "switches after reset");
    host.xfer(1'b0, ADDR_STATUS, 32'h0000_0000, q);
    check(q, 32'h0000_0000, "setup cleared");
    host.setup();
    rd(CMD_GET_AMPLIFICATION, 32'h0000_0000, "gain after reset");
  endtask : test_mid_reset

  // Main sequence: reset for 20 cycles, then the scenarios
  initial begin
    reset = 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    test_reset_and_ids();
    test_label();
    test_corners();
    test_gain_coupling();
    test_lanes();
    test_mid_reset();
    end_sim();
  end

  // Watchdog: the whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule : tb_top
